// ---- src/program_trigger_sequencer.sv ----
// Program and measurement trigger sequencer with AXI4-Lite registers.
// Assumes keys, meas_done, source_changed and output_on are synchronous to aclk;
// the three connector pins are asynchronous and are synchronised here.
//
// How it works
// R01: Run restarts the program at step one, then advances each interval.
// R02: Normal mode moves one step per program interval expiry.
// R03: Single step runs the present step and stops when the interval ends.
// R04: Hold pauses; a second hold resumes keeping the remaining interval time.
// R05: Falling edge on chain or coax trigger input acts as a step request.
// R06: Measure-done mode advances on each measurement completion, ignoring the interval.
// R07: Software must choose source-change completion as measurement source for measure-done.
// R08: Measure-done mode ignores run, step and hold keys and the interval.
// R09: Measurement timer fires periodically, period 0.1 s up to 3600.0 s.
// R10: Measurement timer restarts from zero when the output switches on.
// R11: Immediate mode starts the next measurement on each completion.
// R12: Source-change completion fires 10 ms after each source level change.
// R13: Command trigger mode starts a measurement on the trigger command.
// R14: Normal mode: busy output low at program trigger, high at interval expiry.
// R15: Measure-done mode: busy output pulses low once per program trigger.
// R16: Pause, continue and toggle commands act like the hold key.
// R17: A measurement trigger during a measurement sets the sampling error.
// R18: Run, step or external trigger while running sets the sampling error.
// R19: Program trigger is driven onto the chain and coax outputs.
// R20: Chain carries program triggers and output state to the next unit.
// R21: Coax connectors select output state, program trigger or ready signals.
// R22: Measure-done mode only takes effect when the measurement option is fitted.
// R23: External inputs pass two flip-flops before falling-edge detection.
`timescale 1ns/1ns
module program_trigger_sequencer #(
   parameter int unsigned TICK_CYCLES = trig_seq_pkg::TICK_CYCLES_DEF,
   parameter int unsigned SETTLE_CYCLES = trig_seq_pkg::SETTLE_CYCLES_DEF,
   parameter int unsigned STEP_W = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire trig_seq_pkg::axil_in_t axil_in,
   output trig_seq_pkg::axil_out_t axil_out,
   input wire logic key_run,
   input wire logic key_step,
   input wire logic key_hold,
   input wire logic meas_option_fitted,
   input wire logic meas_done,
   input wire logic source_changed,
   input wire logic output_on,
   input wire logic trigger_input_pin,
   input wire logic coax_in_pin,
   input wire logic chain_state_in_pin,
   output logic trigger_busy_output,
   output logic chain_state_out,
   output logic coax_out,
   output logic meas_start,
   output logic step_advance,
   output logic sampling_error
);
   import trig_seq_pkg::*;

   localparam int PRE_W = $clog2(TICK_CYCLES + 1);
   localparam int SET_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
   localparam logic [SET_W-1:0] SET_LOAD = SET_W'(SETTLE_CYCLES);

   typedef enum logic [1:0] {PRG_IDLE, PRG_RUN, PRG_SINGLE, PRG_PAUSE} prg_state_t;

   function automatic logic [DATA_W-1:0] wmerge(input logic [DATA_W-1:0] old_v,
                                               input logic [DATA_W-1:0] new_v,
                                               input logic [3:0] strb);
      logic [DATA_W-1:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : wmerge

   // Register bus state
   axil_out_t bus_r;
   logic aw_got_r;
   logic w_got_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [DATA_W-1:0] wdata_r;
   logic [3:0] wstrb_r;
   logic [CTRL_W-1:0] ctrl_r;
   logic [DATA_W-1:0] interval_r;
   logic [15:0] period_r;

   // Pin synchronisers: index 0 chain trigger, 1 coax, 2 chain state
   logic [2:0] pin_raw;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [2:0] sync3_r;

   // Program and measurement state
   prg_state_t state_r;
   prg_state_t state_nxt;
   prg_state_t ret_r;
   prg_state_t ret_nxt;
   logic [DATA_W-1:0] ivl_r;
   logic [DATA_W-1:0] ivl_nxt;
   logic [STEP_W-1:0] step_r;
   logic [STEP_W-1:0] step_nxt;
   logic trig_start;
   logic trig_now;
   logic expire;
   logic busy_r;
   logic busy_nxt;
   logic adv_r;
   logic serr_r;
   logic mbusy_r;
   logic mstart_r;
   logic option_r;
   logic out_state_prev_r;
   logic [PRE_W-1:0] pre_r;
   logic [15:0] per_r;
   logic [SET_W-1:0] settle_r;
   logic ready_r;
   logic chain_out_r;
   logic coax_r;

   // Bus decode
   wire write_fire = aw_got_r && w_got_r && !bus_r.bvalid;
   wire read_fire = axil_in.arvalid && bus_r.arready;
   wire wr_ctrl = write_fire && waddr_r == OFS_CTRL;
   wire wr_ivl = write_fire && waddr_r == OFS_INTERVAL;
   wire wr_per = write_fire && waddr_r == OFS_PERIOD;
   wire wr_cmd = write_fire && waddr_r == OFS_CMD;
   wire wr_stat = write_fire && waddr_r == OFS_STATUS;
   wire wr_hit = wr_ctrl || wr_ivl || wr_per || wr_cmd || wr_stat;
   wire [DATA_W-1:0] wval = wmerge(32'h0000_0000, wdata_r, wstrb_r);
   wire [DATA_W-1:0] per_m = wmerge({16'h0000, period_r}, wdata_r, wstrb_r);
   wire [DATA_W-1:0] ctrl_m = wmerge({27'h000_0000, ctrl_r}, wdata_r, wstrb_r);
   wire [15:0] per_w = per_m[31:16] != 16'h0000 ? PERIOD_MAX : per_m[15:0];
   wire [15:0] per_clamped = per_w < PERIOD_MIN ? PERIOD_MIN : (per_w > PERIOD_MAX ? PERIOD_MAX : per_w);
   wire cmd_run = wr_cmd && wval[CMD_RUN_BIT];
   wire cmd_step = wr_cmd && wval[CMD_STEP_BIT];
   wire cmd_pause = wr_cmd && wval[CMD_PAUSE_BIT];
   wire cmd_cont = wr_cmd && wval[CMD_CONT_BIT];
   wire cmd_toggle = wr_cmd && wval[CMD_TOGGLE_BIT];
   wire cmd_trg = wr_cmd && wval[CMD_TRG_BIT];
   wire serr_clr = wr_stat && wval[ST_SERR_BIT];

   // Mode decode
   wire mend = ctrl_r[CTRL_MEND_BIT] && option_r; // see R22
   wire [1:0] msrc = ctrl_r[CTRL_MSRC_LSB +: 2];
   wire [1:0] coax_mode = ctrl_r[CTRL_COAX_LSB +: 2];
   wire coax_is_trig = coax_mode == COAX_TRIG;
   wire coax_is_state = coax_mode == COAX_STATE;

   // Edge detect reads only stages two and three
   wire [2:0] fall = sync3_r & ~sync2_r; // see R23
   wire ext_trig = fall[0] || (fall[1] && coax_is_trig); // see R05
   wire keys_ok = !mend; // see R08
   wire run_req = (key_run && keys_ok) || cmd_run; // see R01
   wire step_req = ((key_step || ext_trig) && keys_ok) || cmd_step; // see R03 R05
   wire hold_tog = (key_hold && keys_ok) || cmd_toggle; // see R04 R16
   wire pause_req = hold_tog || cmd_pause; // see R16
   wire resume_req = hold_tog || cmd_cont; // see R16
   wire prog_active = state_r == PRG_RUN || state_r == PRG_SINGLE;
   wire prog_err = (run_req || step_req) && prog_active; // see R18

   // Output state, local or from upstream unit
   wire out_state = output_on || sync2_r[2] || (coax_is_state && sync2_r[1]); // see R20 R21
   wire out_on_rise = out_state && !out_state_prev_r;

   // Measurement triggers
   wire tick = pre_r == PRE_LAST;
   wire tmr_fire = tick && per_r >= period_r - 16'h0001; // see R09
   wire ready_evt = settle_r == SET_W'(1); // see R12
   wire meas_trig = (msrc == MSRC_TIMER && tmr_fire)
                 || (msrc == MSRC_IMMED && (meas_done || out_on_rise)) // see R11
                 || (msrc == MSRC_READY && ready_evt) // see R07 R12
                 || (msrc == MSRC_COMM && cmd_trg); // see R13
   wire meas_ok = meas_trig && (!mbusy_r || meas_done);
   wire meas_err = meas_trig && mbusy_r && !meas_done; // see R17

   wire [DATA_W-1:0] status_v = {STEP_W'(0) | step_r, 11'h000, mbusy_r, busy_r, serr_r,
                                 state_r == PRG_PAUSE, prog_active};
   wire [DATA_W-1:0] rd_mux =
      axil_in.araddr == OFS_CTRL ? {27'h000_0000, ctrl_r} :
      axil_in.araddr == OFS_INTERVAL ? interval_r :
      axil_in.araddr == OFS_PERIOD ? {16'h0000, period_r} :
      axil_in.araddr == OFS_STATUS ? status_v : 32'h0000_0000;
   wire rd_hit = axil_in.araddr == OFS_CTRL || axil_in.araddr == OFS_INTERVAL
              || axil_in.araddr == OFS_PERIOD || axil_in.araddr == OFS_CMD
              || axil_in.araddr == OFS_STATUS;

   // Program sequencer
   always_comb begin
      state_nxt = state_r;
      ret_nxt = ret_r;
      ivl_nxt = ivl_r;
      step_nxt = step_r;
      trig_start = 1'b0;
      trig_now = 1'b0;
      expire = 1'b0;
      if (run_req && !prog_active) begin
         state_nxt = PRG_RUN; // see R01
         step_nxt = STEP_W'(1);
         ivl_nxt = interval_r;
         trig_start = 1'b1;
         trig_now = 1'b1;
      end else if (step_req && !prog_active) begin
         state_nxt = PRG_SINGLE; // see R03
         ivl_nxt = interval_r;
         trig_start = 1'b1;
         trig_now = 1'b1;
      end else begin
         case (state_r)
            PRG_RUN, PRG_SINGLE: begin
               if (pause_req) begin
                  ret_nxt = state_r; // see R04
                  state_nxt = PRG_PAUSE;
               end else if (mend) begin
                  if (meas_done) begin
                     step_nxt = step_r + STEP_W'(1); // see R06
                     trig_now = 1'b1;
                     if (state_r == PRG_SINGLE) begin
                        state_nxt = PRG_IDLE;
                     end
                  end
               end else if (ivl_r <= 32'h0000_0001) begin
                  expire = 1'b1;
                  step_nxt = step_r + STEP_W'(1); // see R02
                  if (state_r == PRG_RUN) begin
                     ivl_nxt = interval_r;
                     trig_now = 1'b1;
                  end else begin
                     state_nxt = PRG_IDLE; // see R03
                  end
               end else begin
                  ivl_nxt = ivl_r - 32'h0000_0001;
               end
            end
            PRG_PAUSE: begin
               if (resume_req) begin
                  state_nxt = ret_r; // see R04
               end
            end
            default: begin
               state_nxt = PRG_IDLE;
            end
         endcase
      end
   end

   // Busy output: held low per interval, or a one-cycle dip in measure-done mode
   always_comb begin
      if (mend) begin
         busy_nxt = !trig_now; // see R15
      end else if (trig_start) begin
         busy_nxt = 1'b0; // see R14
      end else if (expire) begin
         busy_nxt = 1'b1; // see R14
      end else if (state_r == PRG_RUN && busy_r) begin
         busy_nxt = 1'b0;
      end else begin
         busy_nxt = busy_r;
      end
   end

   assign pin_raw = {chain_state_in_pin, coax_in_pin, trigger_input_pin};

   generate
      for (genvar g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sync1_r[g] <= 1'b1;
               sync2_r[g] <= 1'b1;
               sync3_r[g] <= 1'b1;
            end else begin
               sync1_r[g] <= pin_raw[g]; // see R23
               sync2_r[g] <= sync1_r[g];
               sync3_r[g] <= sync2_r[g];
            end
         end
      end
   endgenerate

   // Bus handshake; write and read each one at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_r <= '0;
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         waddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else begin
         bus_r.awready <= axil_in.awvalid && !aw_got_r && !bus_r.awready && !bus_r.bvalid;
         bus_r.wready <= axil_in.wvalid && !w_got_r && !bus_r.wready && !bus_r.bvalid;
         if (axil_in.awvalid && bus_r.awready) begin
            aw_got_r <= 1'b1;
            waddr_r <= axil_in.awaddr;
         end
         if (axil_in.wvalid && bus_r.wready) begin
            w_got_r <= 1'b1;
            wdata_r <= axil_in.wdata;
            wstrb_r <= axil_in.wstrb;
         end
         if (write_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bus_r.bvalid <= 1'b1;
            bus_r.bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (axil_in.bready) begin
            bus_r.bvalid <= 1'b0;
         end
         bus_r.arready <= axil_in.arvalid && !bus_r.arready && !bus_r.rvalid;
         if (read_fire) begin
            bus_r.rvalid <= 1'b1;
            bus_r.rdata <= rd_mux;
            bus_r.rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (axil_in.rready) begin
            bus_r.rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
         interval_r <= INTERVAL_RST;
         period_r <= PERIOD_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= ctrl_m[CTRL_W-1:0];
         end
         if (wr_ivl) begin
            interval_r <= wmerge(interval_r, wdata_r, wstrb_r);
         end
         if (wr_per) begin
            period_r <= per_clamped; // see R09
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= PRG_IDLE;
         ret_r <= PRG_RUN;
         ivl_r <= '0;
         step_r <= STEP_W'(1);
         busy_r <= 1'b1;
         adv_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ret_r <= ret_nxt;
         ivl_r <= ivl_nxt;
         step_r <= step_nxt;
         busy_r <= busy_nxt;
         adv_r <= step_nxt != step_r && !trig_start;
      end
   end

   // Sampling error: a new error wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serr_r <= 1'b0;
      end else begin
         serr_r <= prog_err || meas_err || (serr_r && !serr_clr); // see R17 R18
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mbusy_r <= 1'b0;
         mstart_r <= 1'b0;
      end else begin
         mstart_r <= meas_ok;
         mbusy_r <= meas_ok || (mbusy_r && !meas_done);
      end
   end

   // Strap caught on the clock, after reset release
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         option_r <= 1'b0;
         out_state_prev_r <= 1'b0;
      end else begin
         option_r <= meas_option_fitted;
         out_state_prev_r <= out_state;
      end
   end

   // Measurement timer, counted in 0.1 s ticks
   always_ff @(posedge aclk) begin
      if (!aresetn || out_on_rise) begin
         pre_r <= '0; // see R10
         per_r <= '0;
      end else begin
         pre_r <= tick ? '0 : pre_r + PRE_W'(1);
         if (tmr_fire) begin
            per_r <= '0;
         end else if (tick) begin
            per_r <= per_r + 16'h0001;
         end
      end
   end

   // Settle delay restarts on every level change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle_r <= '0;
         ready_r <= 1'b0;
      end else begin
         ready_r <= ready_evt;
         if (source_changed) begin
            settle_r <= SET_LOAD; // see R12
         end else if (settle_r != '0) begin
            settle_r <= settle_r - SET_W'(1);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chain_out_r <= 1'b0;
         coax_r <= 1'b1;
      end else begin
         chain_out_r <= out_state; // see R20
         case (coax_mode)
            COAX_STATE: coax_r <= out_state; // see R21
            COAX_TRIG: coax_r <= busy_nxt; // see R19
            COAX_READY: coax_r <= !ready_evt;
            default: coax_r <= 1'b1;
         endcase
      end
   end

   assign axil_out = bus_r;
   assign trigger_busy_output = busy_r; // see R19 R20
   assign chain_state_out = chain_out_r;
   assign coax_out = coax_r;
   assign meas_start = mstart_r;
   assign step_advance = adv_r;
   assign sampling_error = serr_r;
endmodule : program_trigger_sequencer

// ---- src/trig_seq_pkg.sv ----
// Shared constants and types for the program trigger sequencer.
// Assumes a 125 MHz system clock and an AXI4-Lite register port.
package trig_seq_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_INTERVAL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h10;

   // Control fields
   localparam int CTRL_W = 5;
   localparam int CTRL_MEND_BIT = 0;
   localparam int CTRL_MSRC_LSB = 1;
   localparam int CTRL_COAX_LSB = 3;
   localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

   // Command bits, write-one pulses
   localparam int CMD_RUN_BIT = 0;
   localparam int CMD_STEP_BIT = 1;
   localparam int CMD_PAUSE_BIT = 2;
   localparam int CMD_CONT_BIT = 3;
   localparam int CMD_TOGGLE_BIT = 4;
   localparam int CMD_TRG_BIT = 5;

   // Status fields
   localparam int ST_RUN_BIT = 0;
   localparam int ST_PAUSE_BIT = 1;
   localparam int ST_SERR_BIT = 2;
   localparam int ST_BUSY_BIT = 3;
   localparam int ST_MBUSY_BIT = 4;
   localparam int ST_STEP_LSB = 16;

   // Program interval in clock cycles; timer period in 0.1 s ticks
   localparam logic [DATA_W-1:0] INTERVAL_RST = 32'h0000_0100;
   localparam logic [15:0] PERIOD_RST = 16'h000A;
   localparam logic [15:0] PERIOD_MIN = 16'h0001;
   localparam logic [15:0] PERIOD_MAX = 16'h8CA0;

   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int TICK_NS = 100_000_000;
   localparam int SETTLE_MS = 10;
   localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES_DEF = SETTLE_MS * 1_000_000 / CLK_PERIOD_NS;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MSRC_TIMER, MSRC_IMMED, MSRC_READY, MSRC_COMM} meas_src_t;
   typedef enum logic [1:0] {COAX_STATE, COAX_TRIG, COAX_READY, COAX_SPARE} coax_mode_t;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axil_in_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } axil_out_t;
endpackage : trig_seq_pkg

// ---- verif/trig_seq_monitor.sv ----
// Port checker for the program trigger sequencer.
// Bound to every sequencer instance; sees its ports only.
`timescale 1ns/1ns
module trig_seq_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire trig_seq_pkg::axil_in_t axil_in,
   input wire trig_seq_pkg::axil_out_t axil_out,
   input wire logic key_run,
   input wire logic meas_option_fitted,
   input wire logic output_on,
   input wire logic trigger_input_pin,
   input wire logic trigger_busy_output,
   input wire logic chain_state_out,
   input wire logic step_advance,
   input wire logic sampling_error
);
   import trig_seq_pkg::*;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_ar_taken;
      axil_in.arvalid && axil_out.arready;
   endsequence
   // Option absent, so the measure-done bit cannot mask the pin
   sequence s_ext_fall;
      $fell(trigger_input_pin) && !meas_option_fitted;
   endsequence
   a_run_busy_low: assert property (key_run && !meas_option_fitted |=> !trigger_busy_output)
      else $error("busy stayed high after run");
   a_ext_busy: assert property (s_ext_fall |-> ##[2:6] !trigger_busy_output)
      else $error("external fall did not start a step");
   a_step_busy_high: assert property (step_advance && !meas_option_fitted |-> trigger_busy_output)
      else $error("busy low at interval expiry");
   a_step_single: assert property (step_advance |=> !step_advance)
      else $error("more than one step per expiry");
   a_read_answer: assert property (s_ar_taken |=> axil_out.rvalid)
      else $error("read answer late");
   a_read_hold: assert property (axil_out.rvalid && !axil_in.rready |=> axil_out.rvalid && $stable(axil_out.rdata))
      else $error("read data dropped before rready");
   a_unmapped_err: assert property (s_ar_taken and axil_in.araddr > OFS_STATUS
      |=> axil_out.rresp == RESP_SLVERR && axil_out.rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_write_answer: assert property (axil_in.wvalid && axil_out.wready |-> ##[1:2] axil_out.bvalid)
      else $error("write answer late");
   a_err_sticky: assert property ($fell(sampling_error) |-> $past(axil_out.bvalid) || axil_out.bvalid)
      else $error("sampling error cleared without a write");
   a_chain_follow: assert property (output_on |=> chain_state_out)
      else $error("output state not forwarded");
endmodule : trig_seq_monitor

bind program_trigger_sequencer trig_seq_monitor u_mon (.aclk, .aresetn, .axil_in, .axil_out, .key_run,
   .meas_option_fitted, .output_on, .trigger_input_pin, .trigger_busy_output, .chain_state_out, .step_advance,
   .sampling_error);

// ---- verif/trig_link_model.sv ----
// Far side: upstream trigger source and chained unit state.
// Trigger and coax pins idle high as with pull-ups, chain state pin idles low; changes follow a clock edge.
`timescale 1ns/1ns
module trig_link_model (
   input wire logic aclk,
   output logic trigger_input_pin,
   output logic coax_in_pin,
   output logic chain_state_in_pin
);
   initial begin
      trigger_input_pin = 1'b1;
      coax_in_pin = 1'b1;
      chain_state_in_pin = 1'b0;
   end
   // Low long enough to pass two sync stages
   task automatic fall(input logic coax);
      @(posedge aclk);
      if (coax) coax_in_pin <= 1'b0;
      else trigger_input_pin <= 1'b0;
      repeat (4) @(posedge aclk);
      coax_in_pin <= 1'b1;
      trigger_input_pin <= 1'b1;
   endtask : fall
   task automatic set_state(input logic on);
      @(posedge aclk);
      chain_state_in_pin <= on;
   endtask : set_state
endmodule : trig_link_model

// ---- verif/tb_top.sv ----
// Self-checking bench for the program trigger sequencer.
// Registers over AXI4-Lite; connector pins come from the link model.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
   import trig_seq_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   axil_in_t ai = '0;
   axil_out_t ao;
   logic [4:0] kp = 5'h00;
   logic fitted = 1'b0;
   logic out_on = 1'b0;
   wire trig_pin, coax_pin, state_pin, busy, chain_out, coax_o, m_start, s_adv, s_err;
   wire [2:0] obs = {m_start, s_adv, ~busy};
   int err_total = 0;
   int checks_done = 0;
   int n;
   logic [31:0] rd;
   logic [1:0] rr;
   logic [3:0] ws = 4'hf;
   logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h20};
   logic [31:0] rv [5] = '{32'h0000_0000, INTERVAL_RST, 32'h0000_000A, 32'h0000_0000, 32'h0000_0000};
   int lo [4] = '{1, 1, 20, 0};
   int hi [4] = '{12, 3, 23, 0};
   always #4 aclk = ~aclk;
   // Short tick and settle counts keep the run brief
   program_trigger_sequencer #(.TICK_CYCLES(10), .SETTLE_CYCLES(20)) DUT (.aclk(aclk),
      .aresetn(aresetn), .axil_in(ai), .axil_out(ao), .key_run(kp[0]), .key_step(kp[1]), .key_hold(kp[2]),
      .meas_option_fitted(fitted), .meas_done(kp[3]), .source_changed(kp[4]), .output_on(out_on),
      .trigger_input_pin(trig_pin), .coax_in_pin(coax_pin), .chain_state_in_pin(state_pin),
      .trigger_busy_output(busy), .chain_state_out(chain_out), .coax_out(coax_o), .meas_start(m_start),
      .step_advance(s_adv), .sampling_error(s_err));
   trig_link_model u_link (.aclk(aclk), .trigger_input_pin(trig_pin), .coax_in_pin(coax_pin),
      .chain_state_in_pin(state_pin));
   task automatic conclude;
      $display("Checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic lim_hit(input int c);
      if (c >= 50) begin
         err_total++;
         conclude();
      end
   endtask : lim_hit
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int c;
      c = 0;
      @(posedge aclk);
      ai.awaddr <= a;
      ai.wdata <= d;
      ai.wstrb <= ws;
      ai.awvalid <= 1'b1;
      ai.wvalid <= 1'b1;
      ai.bready <= 1'b1;
      do begin
         @(posedge aclk);
         c++;
         if (ao.awready) ai.awvalid <= 1'b0;
         if (ao.wready) ai.wvalid <= 1'b0;
      end while (!ao.bvalid && c < 50);
      rr = ao.bresp;
      ai.bready <= 1'b0;
      lim_hit(c);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      int c;
      c = 0;
      @(posedge aclk);
      ai.araddr <= a;
      ai.arvalid <= 1'b1;
      ai.rready <= 1'b1;
      do begin
         @(posedge aclk);
         c++;
         if (ao.arready) ai.arvalid <= 1'b0;
      end while (!ao.rvalid && c < 50);
      rd = ao.rdata;
      rr = ao.rresp;
      ai.rready <= 1'b0;
      lim_hit(c);
   endtask : rdr
   task automatic pl(input int b);
      @(posedge aclk);
      kp[b] <= 1'b1;
      @(posedge aclk);
      kp[b] <= 1'b0;
   endtask : pl
   // Caller compares n; an exhausted bound shows as a mismatch there
   // Looks at the present edge first: a one-cycle strobe may stand right now
   task automatic wf(input int b, input int l);
      n = 0;
      while (obs[b] !== 1'b1 && n < l) begin
         @(posedge aclk);
         n++;
      end
   endtask : wf
   task automatic start(input logic [31:0] ctrl);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wr(OFS_CTRL, ctrl);
      wr(OFS_INTERVAL, 32'h0000_0040);
   endtask : start
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rdr(ra[i]);
         `CHK({rd, rr}, {rv[i], (i == 4) ? RESP_SLVERR : RESP_OKAY})
      end
      ws = 4'h1;
      wr(OFS_INTERVAL, 32'hFFFF_FF55);
      ws = 4'hf;
      rdr(OFS_INTERVAL);
      `CHK(rd, 32'h0000_0155)
      wr(OFS_PERIOD, 32'h0000_0000);
      rdr(OFS_PERIOD);
      `CHK(rd, 32'h0000_0001)
      wr(OFS_PERIOD, 32'h0000_8CA1);
      rdr(OFS_PERIOD);
      `CHK(rd, 32'h0000_8CA0)
      wr(8'h20, 32'h0000_0001);
      `CHK(rr, RESP_SLVERR)
      start(32'h0000_0000);
      pl(0);
      wf(0, 10);
      `CHK(n, 1)
      wf(1, 100);
      `CHK(n, 64)
      pl(0);
      rdr(OFS_STATUS);
      `CHK({rd[31:16], rd[2]}, {16'h0002, 1'b1})
      wr(OFS_STATUS, 32'h0000_0004);
      rdr(OFS_STATUS);
      `CHK(rd[2], 1'b0)
      pl(2);
      rdr(OFS_STATUS);
      `CHK(rd[1:0], 2'b10)
      wf(1, 80);
      `CHK(n, 80)
      pl(2);
      wf(1, 100);
      `CHK(n > 20 && n < 60, 1'b1)
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CMD, 32'(1 << (2 + ((i < 2) ? i : 2))));
         rdr(OFS_STATUS);
         `CHK(rd[1:0], {~i[0], i[0]})
      end
      start(32'h0000_0000);
      pl(1);
      wf(1, 100);
      rdr(OFS_STATUS);
      `CHK({rd[0], busy, n < 100}, 3'b011)
      u_link.fall(1'b0);
      wf(0, 20);
      `CHK(n < 8, 1'b1)
      u_link.fall(1'b0);
      rdr(OFS_STATUS);
      `CHK(rd[2], 1'b1)
      fitted <= 1'b1;
      start(32'h0000_0005);
      wr(OFS_CMD, 32'h0000_0001);
      pl(0);
      rdr(OFS_STATUS);
      `CHK(rd[2], 1'b0)
      pl(3);
      wf(1, 10);
      `CHK(n < 4, 1'b1)
      `CHK(busy, 1'b0)
      repeat (2) @(posedge aclk);
      `CHK(busy, 1'b1)
      fitted <= 1'b0;
      start(32'h0000_0001);
      pl(0);
      wf(0, 10);
      `CHK(n, 1)
      for (int m = 0; m < 4; m++) begin
         start(32'(m << 1));
         case (m)
            0: wr(OFS_PERIOD, 32'h0000_0001);
            1: pl(3);
            2: pl(4);
            default: wr(OFS_CMD, 32'h0000_0020);
         endcase
         wf(2, 60);
         `CHK(n >= lo[m] && n <= hi[m], 1'b1)
         repeat (12) @(posedge aclk);
         `CHK(s_err, m == 0)
      end
      out_on <= 1'b1;
      start(32'h0000_0008);
      u_link.fall(1'b1);
      wf(0, 20);
      `CHK({n < 8, coax_o, chain_out}, {1'b1, busy, 1'b1})
      out_on <= 1'b0;
      u_link.set_state(1'b1);
      repeat (5) @(posedge aclk);
      `CHK(chain_out, 1'b1)
      conclude();
   end
endmodule : tb_top
